// file: pkg/vdh_pkg.sv
// Contract
// R1: address bit 20 low selects local DRAM
// R2: DRAM takes byte and word accesses
// R3: both select bits high means FIFO write
// R4: device captures FIFO data at strobe fall
// R5: device advances FIFO pointers per write
// R6: FIFO is dual-ported, independent of host clock
// R7: hold address strobe and direction high in DMA
// R8: device captures DMA data at word strobe fall
// R9: vector acknowledge needs enable, pending irq, stable address
// R10: device delays read acknowledge two core cycles minimum
// R11: read data valid with acknowledge
// R12: host drops strobes after taking read data
// R13: device acknowledges writes after byte strobes
// R14: host ends writes by releasing address strobe
// R15: no acknowledge if strobe drops first
// R16: FIFO writes are full words only
// R17: device drains FIFO into DRAM itself
// R18: DMA controller answers request with one word
// R19: device commits FIFO word three core cycles later
// R20: no strobes for three core periods; direction low
// R21: address strobe high two core cycles between writes
// R22: device acknowledges FIFO writes without waits
// R23: polled writes only while FIFO has room
// R24: register select uses seven word address bits
// R25: both byte strobes for word, one for byte
// R26: device synchronises host strobes internally
package vdh_pkg;

  // ************************************************
  // timing
  // ************************************************
  localparam int SYS_CLK_NS = 20;
  localparam int CORE_CLK_NS = 40;
  localparam int FIFO_SETTLE_CORE = 3;
  localparam int GAP_NS = FIFO_SETTLE_CORE * CORE_CLK_NS;
  localparam int GAP_CYCLES_I = (GAP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [7:0] GAP_CYCLES = 8'(GAP_CYCLES_I);
  localparam logic [7:0] WORD_STROBE_CYCLES = 8'h02;
  localparam logic [7:0] ACK_TIMEOUT = 8'hff;

  // ************************************************
  // address map
  // ************************************************
  localparam logic [1:0] SEL_DRAM0 = 2'h0;
  localparam logic [1:0] SEL_DRAM1 = 2'h1;
  localparam logic [1:0] SEL_REG = 2'h2;
  localparam logic [1:0] SEL_FIFO = 2'h3;
  localparam int SEL_HI = 20;
  localparam int SEL_LO = 19;
  localparam int VECTOR_EN_BIT = 14;

  // ************************************************
  // types
  // ************************************************
  typedef enum logic [1:0] {
    VDH_READ = 2'h0,
    VDH_WRITE = 2'h1,
    VDH_FIFO = 2'h2,
    VDH_VECTOR = 2'h3
  } vdh_kind_type;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_STROBE = 9'h004,
    S_WAIT = 9'h008,
    S_RELEASE = 9'h010,
    S_GAP = 9'h020,
    S_DMA_ACK = 9'h040,
    S_DMA_STROBE = 9'h080,
    S_DMA_END = 9'h100
  } vdh_state_type;

  typedef struct packed {
    vdh_kind_type kind;
    logic [20:1] addr;
    logic upper_en;
    logic lower_en;
    logic [15:0] data;
  } vdh_cmd_type;

  typedef struct packed {
    logic [15:0] data;
    logic err;
  } vdh_rsp_type;

  typedef struct packed {
    logic [20:1] addr;
    logic address_strobe_n;
    logic upper_byte_strobe_n;
    logic lower_byte_strobe_n;
    logic read_not_write;
    logic [15:0] data_o;
    logic data_oe;
    logic dma_acknowledge_in_n;
    logic dma_word_strobe_n;
    logic interrupt_acknowledge_in_n;
    logic host_clock;
  } vdh_pins_type;

  typedef struct packed {
    vdh_state_type state;
    logic [7:0] cnt;
    vdh_kind_type kind;
    vdh_pins_type pins;
    vdh_rsp_type rsp;
    logic rsp_valid;
  } vdh_regs_type;

  localparam vdh_pins_type PINS_IDLE = '{
    addr: 20'h00000, address_strobe_n: 1'h1, upper_byte_strobe_n: 1'h1,
    lower_byte_strobe_n: 1'h1, read_not_write: 1'h1, data_o: 16'h0000,
    data_oe: 1'h0, dma_acknowledge_in_n: 1'h1, dma_word_strobe_n: 1'h1,
    interrupt_acknowledge_in_n: 1'h1, host_clock: 1'h0};

endpackage

// file: rtl/vdh_host.sv
`timescale 1ns/1ns
module vdh_host
  import vdh_pkg::*;
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // command port
  input wire logic cmd_valid,
  input wire vdh_cmd_type cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output vdh_rsp_type rsp,
  // dma word source and vector enable
  input wire logic dma_enable,
  input wire logic dma_valid,
  input wire logic [15:0] dma_data,
  output logic dma_ready,
  input wire logic vector_irq_enable,
  // device pins
  output vdh_pins_type pins,
  input wire logic [15:0] data_in,
  input wire logic transfer_acknowledge_n,
  input wire logic dma_request_out_n,
  input wire logic irq_n,
  input wire logic fifo_level_flag
);

  // ************************************************
  // reset release
  // ************************************************
  logic [1:0] rsync_q;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rsync_q <= 2'h0;
    end else begin
      rsync_q <= {rsync_q[0], 1'h1};
    end
  end

  assign rst_n = rsync_q[1];

  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [19:0] sync_q;
  logic [15:0] data_seen;
  logic ack_seen;
  logic req_seen;
  logic irq_seen;
  logic room_seen;

  vdh_sync #(.W(20)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d({data_in, ~transfer_acknowledge_n, ~dma_request_out_n, ~irq_n,
        fifo_level_flag}),
    .q(sync_q)
  );

  assign data_seen = sync_q[19:4];
  assign ack_seen = sync_q[3];
  assign req_seen = sync_q[2];
  assign irq_seen = sync_q[1];
  assign room_seen = sync_q[0];

  // ************************************************
  // handshakes
  // ************************************************
  vdh_regs_type st_q;
  vdh_regs_type st_d;

  // polled writes wait for room [R23]
  assign cmd_ready = clk_en && (st_q.state == S_IDLE) &&
                     ((cmd.kind != VDH_FIFO) || room_seen);
  // a word goes out only against a pending request [R18]
  assign dma_ready = clk_en && (st_q.state == S_IDLE) && !cmd_valid &&
                     dma_enable && req_seen;

  // byte enables are held from the accepted command
  logic upper_q;
  logic lower_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_q <= 1'h1;
      lower_q <= 1'h1;
    end else if (clk_en && cmd_valid && cmd_ready) begin
      upper_q <= cmd.upper_en;
      lower_q <= cmd.lower_en;
    end
  end

  // ************************************************
  // sequencer
  // ************************************************
  always_comb begin
    st_d = st_q;
    st_d.rsp_valid = 1'h0;
    st_d.pins.host_clock = ~st_q.pins.host_clock;
    case (st_q.state)
      S_IDLE: begin
        st_d.cnt = 8'h00;
        if (cmd_valid && cmd_ready) begin
          st_d.kind = cmd.kind;
          // address settles a full cycle before any strobe [R3]
          st_d.pins.addr = cmd.addr;
          st_d.pins.read_not_write = (cmd.kind == VDH_READ) ||
                                     (cmd.kind == VDH_VECTOR);
          st_d.pins.data_o = cmd.data;
          if (cmd.kind == VDH_FIFO) begin
            st_d.pins.addr[SEL_HI:SEL_LO] = SEL_FIFO; // [R3]
          end
          if ((cmd.kind == VDH_VECTOR) &&
              !(vector_irq_enable && irq_seen)) begin
            // refused: no pending irq or vectors disabled [R9]
            st_d.rsp = '{data: 16'h0000, err: 1'h1};
            st_d.rsp_valid = 1'h1;
          end else begin
            st_d.state = S_ADDR;
          end
        end else if (dma_valid && dma_ready) begin
          // strobe and direction stay high for dma [R7]
          st_d.pins.address_strobe_n = 1'h1;
          st_d.pins.read_not_write = 1'h1;
          st_d.pins.data_o = dma_data;
          st_d.pins.data_oe = 1'h1;
          st_d.pins.dma_acknowledge_in_n = 1'h0; // [R18]
          st_d.state = S_DMA_ACK;
        end
      end
      S_ADDR: begin
        if (st_q.kind == VDH_VECTOR) begin
          st_d.pins.interrupt_acknowledge_in_n = 1'h0; // [R9]
          st_d.state = S_WAIT;
        end else begin
          st_d.pins.address_strobe_n = 1'h0;
          if (st_q.kind == VDH_READ) begin
            // byte lane choice on reads too [R25]
            st_d.pins.upper_byte_strobe_n = ~cmd_upper(st_q);
            st_d.pins.lower_byte_strobe_n = ~cmd_lower(st_q);
            st_d.state = S_WAIT;
          end else begin
            st_d.state = S_STROBE;
          end
        end
      end
      S_STROBE: begin
        // write data is driven in the same cycle as the byte strobes
        st_d.pins.data_oe = 1'h1;
        if (st_q.kind == VDH_FIFO) begin
          st_d.pins.upper_byte_strobe_n = 1'h0; // [R16]
          st_d.pins.lower_byte_strobe_n = 1'h0; // [R16]
        end else begin
          st_d.pins.upper_byte_strobe_n = ~cmd_upper(st_q); // [R25]
          st_d.pins.lower_byte_strobe_n = ~cmd_lower(st_q); // [R25]
        end
        st_d.state = S_WAIT;
      end
      S_WAIT: begin
        st_d.cnt = st_q.cnt + 8'h01;
        if (ack_seen || (st_q.cnt == ACK_TIMEOUT)) begin
          // read data is taken in the same cycle the ack is seen
          st_d.rsp.data = data_seen;
          st_d.rsp.err = !ack_seen;
          st_d.rsp_valid = 1'h1;
          // drop every strobe together [R12] [R14]
          st_d.pins.address_strobe_n = 1'h1;
          st_d.pins.upper_byte_strobe_n = 1'h1;
          st_d.pins.lower_byte_strobe_n = 1'h1;
          st_d.pins.interrupt_acknowledge_in_n = 1'h1;
          st_d.pins.data_oe = 1'h0;
          st_d.state = S_RELEASE;
        end
      end
      S_RELEASE: begin
        // a timed-out cycle never sees an ack, so nothing waits here
        st_d.cnt = 8'h00;
        if (!ack_seen) begin
          st_d.state = S_GAP;
        end
      end
      S_GAP: begin
        // keeps strobes off while the device commits a word [R20] [R21]
        st_d.cnt = st_q.cnt + 8'h01;
        if (st_q.cnt == GAP_CYCLES - 8'h01) begin
          st_d.state = S_IDLE;
        end
      end
      S_DMA_ACK: begin
        st_d.pins.dma_word_strobe_n = 1'h0;
        st_d.cnt = 8'h00;
        st_d.state = S_DMA_STROBE;
      end
      S_DMA_STROBE: begin
        st_d.cnt = st_q.cnt + 8'h01;
        if (st_q.cnt == WORD_STROBE_CYCLES - 8'h01) begin
          st_d.pins.dma_word_strobe_n = 1'h1;
          st_d.state = S_DMA_END;
        end
      end
      S_DMA_END: begin
        // acknowledge high time plays the strobe gap role [R21]
        st_d.pins.dma_acknowledge_in_n = 1'h1;
        st_d.pins.data_oe = 1'h0;
        st_d.cnt = 8'h00;
        st_d.state = S_GAP;
      end
      default: begin
        st_d.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{state: S_IDLE, cnt: 8'h00, kind: VDH_READ,
                pins: PINS_IDLE, rsp: '0, rsp_valid: 1'h0};
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  function automatic logic cmd_upper(input vdh_regs_type s);
    cmd_upper = (s.kind == VDH_READ || s.kind == VDH_WRITE) ?
                upper_q : 1'h1;
  endfunction

  function automatic logic cmd_lower(input vdh_regs_type s);
    cmd_lower = (s.kind == VDH_READ || s.kind == VDH_WRITE) ?
                lower_q : 1'h1;
  endfunction

  assign pins = st_q.pins;
  assign rsp = st_q.rsp;
  assign rsp_valid = st_q.rsp_valid;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  logic fifo_op;
  assign fifo_op = (st_q.kind == VDH_FIFO);

  sequence strobe_quiet;
    st_q.pins.address_strobe_n && st_q.pins.lower_byte_strobe_n &&
    st_q.pins.upper_byte_strobe_n;
  endsequence

  sequence gap_hold;
    strobe_quiet [*6];
  endsequence

  fifo_select_a: assert property ( // [R3]
    $fell(st_q.pins.address_strobe_n) && fifo_op |->
    st_q.pins.addr[SEL_HI:SEL_LO] == SEL_FIFO &&
    $stable(st_q.pins.addr))
    else $error("fifo select bits not set before strobe");

  dma_strobe_high_a: assert property ( // [R7]
    !st_q.pins.dma_acknowledge_in_n |->
    st_q.pins.address_strobe_n && st_q.pins.read_not_write)
    else $error("strobe or direction low during dma");

  vector_hold_a: assert property ( // [R9]
    !st_q.pins.interrupt_acknowledge_in_n &&
    !$past(st_q.pins.interrupt_acknowledge_in_n) |->
    $stable(st_q.pins.addr[3:1]))
    else $error("vector address moved during acknowledge");

  read_release_a: assert property ( // [R12]
    st_q.state == S_WAIT && ack_seen && clk_en |=> strobe_quiet)
    else $error("strobes not dropped after read data");

  write_end_a: assert property ( // [R14]
    st_q.rsp_valid |-> st_q.pins.address_strobe_n && !st_q.pins.data_oe)
    else $error("address strobe held after answer");

  fifo_word_a: assert property ( // [R16]
    fifo_op && !st_q.pins.address_strobe_n |->
    st_q.pins.lower_byte_strobe_n == st_q.pins.upper_byte_strobe_n)
    else $error("byte wide fifo write");

  fifo_dir_low_a: assert property ( // [R20]
    $fell(st_q.pins.lower_byte_strobe_n) && fifo_op |->
    !st_q.pins.read_not_write)
    else $error("direction high at fifo strobe");

  strobe_gap_a: assert property ( // [R21]
    $rose(st_q.pins.address_strobe_n) |-> gap_hold)
    else $error("address strobe high time too short");

  dma_answer_a: assert property ( // [R18]
    $fell(st_q.pins.dma_acknowledge_in_n) && clk_en |->
    $past(req_seen) ##1 !st_q.pins.dma_word_strobe_n)
    else $error("dma word without request");

  poll_room_a: assert property ( // [R23]
    $fell(st_q.pins.address_strobe_n) && fifo_op |-> $past(room_seen, 2))
    else $error("fifo write without room");

endmodule

// file: rtl/vdh_sync.sv
`timescale 1ns/1ns
module vdh_sync
  import vdh_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ************************************************
  // two stage synchroniser
  // ************************************************
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } vdh_sync_regs_type;

  vdh_sync_regs_type r_q;
  vdh_sync_regs_type r_d;

  always_comb begin
    r_d = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '0;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;

endmodule

// file: testbench/vdh_dev.sv
`timescale 1ns/1ns
module vdh_dev
  import vdh_pkg::*;
#(
  parameter logic [15:0] VEC = 16'h5a30
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // pins
  input wire vdh_pins_type pins,
  output logic [15:0] data_in,
  output logic transfer_acknowledge_n,
  output logic dma_request_out_n,
  output logic irq_n,
  output logic fifo_level_flag,
  // scenario controls
  input wire logic [1:0] read_wait,
  input wire logic mute,
  input wire logic irq_req,
  input wire logic drain_en
);
  // ************************************************
  // device model; vector base value is arbitrary
  // ************************************************
  logic [15:0] mem [0:639];
  logic [15:0] fq [$];
  logic [15:0] log_q [$];
  logic [15:0] drv, cap;
  logic [15:0] flip = 16'h0ff0;
  logic [3:0] s1, s2;
  logic [2:0] va;
  logic [1:0] lane;
  logic ack_n, drv_en, done, req, armed;
  int viol, wc, strobe_hi, dk_hi;
  time t_up;
  wire logic [1:0] sel = pins.addr[SEL_HI:SEL_LO];
  wire logic [9:0] key = sel == SEL_REG ? {3'h4, pins.addr[7:1]} :
    {1'b0, sel[0], pins.addr[8:1]};
  wire logic vec = !s2[3];
  wire logic acc = !s2[2] && s2[1:0] != 2'h3 && sel != SEL_FIFO;
  assign irq_n = !irq_req;
  // fifo writes need no arbitration, so the answer is immediate
  assign transfer_acknowledge_n = ack_n && !(!pins.address_strobe_n &&
    sel == SEL_FIFO && !pins.read_not_write);
  // an undriven lane toggles so that a stale value cannot pass
  always_comb begin
    data_in = pins.data_oe ? pins.data_o : flip;
    if (drv_en && lane[1]) data_in[15:8] = drv[15:8];
    if (drv_en && lane[0]) data_in[7:0] = drv[7:0];
  end
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {ack_n, drv_en, done} <= 3'h4;
      req = 1'b0;
      {wc, strobe_hi, dk_hi} <= {32'd0, 32'd8, 32'd8};
      {s1, s2} <= 8'hff;
      {fifo_level_flag, dma_request_out_n} <= 2'h2;
    end else begin
      s1 <= {pins.interrupt_acknowledge_in_n, pins.address_strobe_n,
        pins.upper_byte_strobe_n, pins.lower_byte_strobe_n};
      s2 <= s1;
      flip <= ~flip;
      strobe_hi <= pins.address_strobe_n ? strobe_hi + 1 : 0;
      dk_hi <= pins.dma_acknowledge_in_n ? dk_hi + 1 : 0;
      if (req) begin
        req = 1'b0;
        if (fq.size() >= 16) viol++;
        fq.push_back(cap);
        log_q.push_back(cap);
      end
      if (drain_en && fq.size() > 0) void'(fq.pop_front());
      fifo_level_flag <= fq.size() < 16;
      dma_request_out_n <= fq.size() >= 16;
      if (!(vec || acc)) begin
        {ack_n, drv_en, done} <= 3'h4;
        wc <= 0;
      end else if (!done && !mute) begin
        if (wc < (pins.read_not_write ? 2 + read_wait : 1)) begin
          wc <= wc + 1;
        end else begin
          {ack_n, done} <= 2'h1;
          lane <= vec ? 2'h3 : ~s2[1:0];
          drv_en <= pins.read_not_write || vec;
          drv <= vec ? VEC | 16'(pins.addr[3:1]) : mem[key];
          if (!pins.read_not_write && !vec) begin
            if (!s2[1]) mem[key][15:8] <= data_in[15:8];
            if (!s2[0]) mem[key][7:0] <= data_in[7:0];
          end
        end
      end
    end
  end
  always @(negedge pins.lower_byte_strobe_n or
    negedge pins.dma_word_strobe_n) begin
    if (!pins.dma_word_strobe_n) begin
      armed = 1'b1;
      cap = pins.data_o;
      if (!pins.address_strobe_n || !pins.read_not_write ||
        pins.dma_acknowledge_in_n) viol++;
    end else if (!pins.address_strobe_n && sel == SEL_FIFO) begin
      armed = 1'b1;
      cap = pins.data_o;
      if (pins.read_not_write || pins.upper_byte_strobe_n) viol++;
      if ($time - t_up < 3 * CORE_CLK_NS) viol++;
    end
  end
  always @(posedge pins.lower_byte_strobe_n or
    posedge pins.dma_word_strobe_n) begin
    if (armed) req = 1'b1;
    armed = 1'b0;
  end
  always @(posedge pins.address_strobe_n) t_up = $time;
  always @(negedge pins.address_strobe_n) begin
    if (sel == SEL_FIFO && strobe_hi < 2) viol++;
  end
  always @(negedge pins.dma_acknowledge_in_n) begin
    if (dk_hi < 2) viol++;
  end
  always @(negedge pins.interrupt_acknowledge_in_n) begin
    va = pins.addr[3:1];
    if (irq_n) viol++;
  end
  always @(posedge pins.interrupt_acknowledge_in_n) begin
    if (va != pins.addr[3:1]) viol++;
  end
endmodule

// file: testbench/video_decoder_host_port_tb.sv
`timescale 1ns/1ns
module video_decoder_host_port_tb;
  import vdh_pkg::*;
  // ************************************************
  // bench
  // ************************************************
  localparam logic [15:0] VEC = 16'h5a30;
  logic sys_clk = 1'b0;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic cmd_valid = 1'b0;
  vdh_cmd_type cmd = '0;
  logic dma_enable = 1'b0;
  logic dma_valid = 1'b0;
  logic [15:0] dma_data = 16'h0000;
  logic vector_irq_enable = 1'b0;
  logic mute = 1'b0;
  logic irq_req = 1'b0;
  logic drain_en = 1'b1;
  logic [1:0] read_wait = 2'h0;
  logic cmd_ready, rsp_valid, dma_ready, transfer_acknowledge_n;
  logic dma_request_out_n, irq_n, fifo_level_flag;
  vdh_rsp_type rsp, got;
  vdh_pins_type pins;
  logic [15:0] data_in, d, x, m;
  logic [15:0] exp_q [$];
  logic [20:1] a;
  logic [1:0] e;
  int num_errors = 0;
  int cmp_count = 0;
  int n, k;
  always #10 sys_clk = ~sys_clk;
  // 42 ns keeps the core clock drifting against the host clock
  always #21 core_clk = ~core_clk;
  // random stalls freeze the host so every wait path sees held state
  always @(negedge sys_clk) clk_en = $urandom_range(0, 3) != 0;
  vdh_host i_vdh_host (.sys_clk, .reset_n, .clk_en, .cmd_valid,
    .cmd, .cmd_ready, .rsp_valid, .rsp, .dma_enable, .dma_valid,
    .dma_data, .dma_ready, .vector_irq_enable, .pins, .data_in,
    .transfer_acknowledge_n, .dma_request_out_n, .irq_n, .fifo_level_flag);
  vdh_dev #(.VEC(VEC)) i_vdh_dev (.core_clk, .reset_n, .pins, .data_in,
    .transfer_acknowledge_n, .dma_request_out_n, .irq_n, .fifo_level_flag,
    .read_wait, .mute, .irq_req, .drain_en);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic hang();
    num_errors++;
    close_out();
  endtask
  task automatic run(input vdh_kind_type kd, input logic [1:0] en,
    input logic [15:0] wd);
    @(negedge sys_clk);
    cmd = '{kind: kd, addr: a, upper_en: en[1], lower_en: en[0], data: wd};
    cmd_valid = 1'b1;
    // ready is looked at on the edge that takes the command
    for (n = 0; n <= 600; n++) begin
      @(posedge sys_clk);
      if (cmd_ready === 1'b1) break;
    end
    if (n > 600) hang();
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    for (n = 0; rsp_valid !== 1'b1; n++) begin
      if (n > 600) hang();
      @(negedge sys_clk);
    end
    got = rsp;
  endtask
  task automatic dma(input logic [15:0] wd);
    @(negedge sys_clk);
    dma_data = wd;
    dma_valid = 1'b1;
    for (n = 0; n <= 600; n++) begin
      @(posedge sys_clk);
      if (dma_ready === 1'b1) break;
    end
    if (n > 600) hang();
    @(negedge sys_clk);
    dma_valid = 1'b0;
  endtask
  function automatic logic [15:0] merge(input logic [15:0] o, w,
    input logic [1:0] en);
    return {en[1] ? w[15:8] : o[15:8], en[0] ? w[7:0] : o[7:0]};
  endfunction
  initial begin
    void'($urandom(32'h1fd3e0c9));
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    for (k = 0; k < 16; k++) begin
      a = 20'($urandom());
      a[20:19] = k < 12 ? 2'(k % 2) : SEL_REG;
      read_wait = 2'($urandom());
      d = 16'($urandom());
      run(VDH_WRITE, 2'h3, d);
      e = k < 12 ? 2'($urandom_range(1, 3)) : 2'h3;
      x = 16'($urandom());
      run(VDH_WRITE, e, x);
      x = merge(d, x, e);
      e = k < 12 ? 2'($urandom_range(1, 3)) : 2'h3;
      m = {{8{e[1]}}, {8{e[0]}}};
      run(VDH_READ, e, 16'h0000);
      check(got.data & m, x & m);
      check(16'(got.err), 16'h0000);
    end
    mute = 1'b1;
    run(VDH_READ, 2'h3, 16'h0000);
    check(16'(got.err), 16'h0001);
    mute = 1'b0;
    drain_en = 1'b0;
    a = 20'($urandom()) | 20'hc0000;
    for (k = 0; k < 16; k++) begin
      run(VDH_FIFO, 2'h1, 16'($urandom()));
      exp_q.push_back(cmd.data);
    end
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    repeat (40) begin
      @(negedge sys_clk);
      check(16'(cmd_ready), 16'h0000);
    end
    cmd_valid = 1'b0;
    drain_en = 1'b1;
    dma_enable = 1'b1;
    for (k = 0; k < 4; k++) begin
      d = 16'($urandom());
      dma(d);
      exp_q.push_back(d);
    end
    dma_enable = 1'b0;
    for (n = 0; i_vdh_dev.log_q.size() < 20; n++) begin
      if (n > 300) hang();
      @(negedge sys_clk);
    end
    foreach (exp_q[i]) check(i_vdh_dev.log_q[i], exp_q[i]);
    irq_req = 1'b1;
    vector_irq_enable = 1'b1;
    a = 20'($urandom());
    repeat (12) @(negedge sys_clk);
    run(VDH_VECTOR, 2'h3, 16'h0000);
    check(got.data, VEC | 16'(a[3:1]));
    vector_irq_enable = 1'b0;
    run(VDH_VECTOR, 2'h3, 16'h0000);
    check(16'(got.err), 16'h0001);
    irq_req = 1'b0;
    check(16'(i_vdh_dev.viol), 16'h0000);
    close_out();
  end
endmodule
